// ===== pcs_host_model.sv
// Host processor model: indexed register master and select pin driver
`timescale 1ns/10ps
`default_nettype none
module pcs_host_model
    import pcs_pkg::*;
(
    // Clock
    input wire logic clk_sys,
    // Register port
    output var logic [7:0] reg_addr,
    output var logic [7:0] reg_wdata,
    output var logic reg_wr,
    output var logic reg_rd,
    input wire logic [7:0] reg_rdata,
    // Pins
    output var logic [1:0] hardwired_freq_select_pins
);
    initial begin
        reg_addr = 8'h00;
        reg_wdata = 8'h00;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        hardwired_freq_select_pins = 2'h0;
    end
    // ****************
    // Bus cycles
    // ****************
    task automatic write_reg(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk_sys);
        reg_wr <= 1'b0;
    endtask
    // Read data stands only in the cycle after the strobe
    task automatic read_reg(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk_sys);
        reg_rd <= 1'b0;
        #1;
        d = reg_rdata;
    endtask
    task automatic set_pins(input logic [1:0] v);
        @(posedge clk_sys);
        hardwired_freq_select_pins <= v;
    endtask
    // ****************
    // Programming steps
    // ****************
    // Stopping first makes memory searches, and pixel and loop searches with pins at 1x, start from rest
    task automatic stop_synth(input logic [7:0] idx);
        write_reg(IDX_PTR, PTR_P);
        write_reg(idx, 8'h00);
    endtask
    task automatic load_synth(input logic [7:0] idx, input logic [7:0] n, input logic [7:0] m, input logic [7:0] p);
        write_reg(IDX_PTR, PTR_N);
        write_reg(idx, n | 8'hC0);
        write_reg(idx, m);
        write_reg(idx, p | 8'h80);
    endtask
    // Gives up after 64 status reads, with ok low, if the synthesizer has not locked
    task automatic poll_lock(input logic [7:0] idx, output logic ok);
        logic [7:0] d;
        ok = 1'b0;
        write_reg(IDX_PTR, PTR_STAT);
        for (int k = 0; k < 64 && !ok; k++) begin
            read_reg(idx, d);
            ok = (d[STAT_LOCK_BIT] === 1'b1);
        end
    endtask
endmodule
`default_nettype wire

// ===== pcs_pkg.sv
// Package: constants for the synthesizer programming sequencer
package pcs_pkg;
    // Register indices
    localparam logic [7:0] IDX_CLK_SRC = 8'h1A;
    localparam logic [7:0] IDX_PTR = 8'h2C;
    localparam logic [7:0] IDX_PIX_DATA = 8'h2D;
    localparam logic [7:0] IDX_MEM_DATA = 8'h2E;
    localparam logic [7:0] IDX_LOOP_DATA = 8'h2F;
    localparam logic [7:0] IDX_MLC_CTRL = 8'h39;
    localparam logic [7:0] IDX_IRQ_STAT = 8'h3A;
    localparam logic [7:0] IDX_IRQ_MASK = 8'h3B;
    // Pointer codes
    localparam logic [7:0] PTR_N = 8'h00;
    localparam logic [7:0] PTR_M = 8'h15;
    localparam logic [7:0] PTR_P = 8'h2A;
    localparam logic [7:0] PTR_STAT = 8'h3F;
    // Field positions
    localparam int P_RUN_BIT = 7;
    localparam int STAT_LOCK_BIT = 6;
    localparam int RCLK_SEL_BIT = 3;
    localparam int Q_MSB = 2;
    localparam int SRC_OFF_LSB = 4;
    localparam logic [2:0] SRC_OFF_ALL = 3'h7;
    localparam logic [3:0] SRC_SEL_SYNTH = 4'h5;
    // Reset values
    localparam logic [7:0] RST_CLK_SRC = 8'h07;
    localparam logic [7:0] RST_MLC = 8'h18;
    localparam logic [7:0] RST_N = 8'hC0;
    localparam logic [7:0] RST_M = 8'h00;
    localparam logic [7:0] RST_P = 8'h80;
    localparam logic [7:0] RST_PIX_P = 8'h00;
    // Hard-wired pixel settings: 25.057 MHz and 28.636 MHz
    localparam logic [7:0] HW0_N = 8'hC0;
    localparam logic [7:0] HW0_M = 8'h28;
    localparam logic [7:0] HW1_N = 8'hC0;
    localparam logic [7:0] HW1_M = 8'h2C;
    localparam logic [7:0] HW_P = 8'hB3;
    // Lock time of a modelled loop, in ns
    localparam int LOCK_TIME_NS = 10000;
    localparam int CLK_PERIOD_NS = 8;
    localparam int LOCK_CYCLES = (LOCK_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int LOCK_CW = 16;
    // Word selector
    typedef enum logic [1:0] {
        PCS_W_N = 2'b00,
        PCS_W_M = 2'b01,
        PCS_W_P = 2'b10,
        PCS_W_S = 2'b11
    } pcs_word_t;
    typedef enum logic [1:0] {
        PCS_ST_STOP = 2'b00,
        PCS_ST_ACQ = 2'b01,
        PCS_ST_LOCK = 2'b10
    } pcs_state_t;
endpackage

// ===== pcs_synth.sv
// Module: one synthesizer run/acquire/lock tracker
`timescale 1ns/10ps
`default_nettype none
module pcs_synth
    import pcs_pkg::*;
#(
    parameter int LOCK_CNT = LOCK_CYCLES
) (
    input wire logic clk_sys,
    input wire logic rst_n,
    // Control
    input wire logic run,
    input wire logic retune,
    // Status
    output logic osc_on,
    output logic locked
);
    pcs_state_t state;
    logic [LOCK_CW-1:0] cnt;

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            state <= PCS_ST_STOP;
            cnt <= '0;
        end else begin
            case (state)
                PCS_ST_STOP: begin
                    cnt <= '0;
                    if (run) begin
                        state <= PCS_ST_ACQ;
                    end
                end
                PCS_ST_ACQ: begin
                    if (!run) begin
                        state <= PCS_ST_STOP;
                    end else if (retune) begin
                        cnt <= '0;
                    end else if (cnt == LOCK_CW'(LOCK_CNT - 1)) begin
                        state <= PCS_ST_LOCK;
                    end else begin
                        cnt <= cnt + 1'b1;
                    end
                end
                PCS_ST_LOCK: begin
                    cnt <= '0;
                    if (!run) begin
                        state <= PCS_ST_STOP;
                    end else if (retune) begin
                        state <= PCS_ST_ACQ;
                    end
                end
                default: state <= PCS_ST_STOP;
            endcase
        end
    end

    assign osc_on = (state != PCS_ST_STOP);
    assign locked = (state == PCS_ST_LOCK);
endmodule
`default_nettype wire

// ===== pcs_tb_top.sv
// Testbench: register sequences of the synthesizer programming sequencer
`timescale 1ns/10ps
`default_nettype none
module pcs_tb_top;
    import pcs_pkg::*;
    localparam int LOCK_SIM = 8;
    logic clk_sys;
    logic rst_n;
    logic [7:0] reg_addr, reg_wdata, reg_rdata;
    logic reg_wr, reg_rd;
    logic [1:0] pins;
    logic pix_run, loop_run, mem_run, rclk_from_pixel, pix_src_synth, video_clock_out_en, irq;
    logic [7:0] pix_n, pix_m, pix_p;
    logic [2:0] loop_q;
    int bad_count;
    int checks;
    logic [7:0] d;
    logic ok;
    logic [7:0] loop_nm [4][2] = '{'{8'hE1, 8'h3D}, '{8'hF1, 8'h3D}, '{8'hF9, 8'hBE}, '{8'hF9, 8'h3D}};
    // ****************
    // Clock and instances
    // ****************
    initial clk_sys = 1'b0;
    always #4 clk_sys = ~clk_sys;
    pcs_host_model i_pcs_host_model (.clk_sys(clk_sys), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .hardwired_freq_select_pins(pins));
    pcs_top #(.LOCK_CNT(LOCK_SIM)) i_pcs_top (.clk_sys(clk_sys), .rst_n(rst_n), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .hardwired_freq_select_pins(pins), .pix_run(pix_run), .loop_run(loop_run), .mem_run(mem_run),
        .pix_n(pix_n), .pix_m(pix_m), .pix_p(pix_p), .loop_q(loop_q), .rclk_from_pixel(rclk_from_pixel),
        .pix_src_synth(pix_src_synth), .video_clock_out_en(video_clock_out_en), .irq(irq));
    // ****************
    // Helpers
    // ****************
    task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
        checks++;
        if (got !== exp) begin
            bad_count++;
            $display("BAD %0t %s got %h expected %h", $time, what, got, exp);
        end
    endtask
    task automatic rchk(input logic [7:0] a, input logic [7:0] exp, input string what);
        logic [7:0] v;
        i_pcs_host_model.read_reg(a, v);
        chk(v, exp, what);
    endtask
    // Derived outputs follow a write by two cycles
    task automatic settle;
        repeat (2) @(posedge clk_sys);
        #1;
    endtask
    task automatic wait_pix(input logic exp);
        for (int k = 0; k < 12 && pix_run !== exp; k++) @(posedge clk_sys);
        #1;
        chk({7'h00, pix_run}, {7'h00, exp}, "pixel run");
    endtask
    task automatic complete_run;
        $display("mismatches %0d comparisons %0d", bad_count, checks);
        if (bad_count == 0 && checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    initial begin
        #600000;
        bad_count++;
        complete_run();
    end
    // ****************
    // Sequence
    // ****************
    initial begin
        bad_count = 0;
        checks = 0;
        rst_n = 1'b0;
        repeat (10) @(posedge clk_sys);
        #1;
        chk({pix_n, pix_m, pix_p} == {HW0_N, HW0_M, HW_P} ? 8'h01 : 8'h00, 8'h01, "reset words");
        chk({3'h0, pix_run, loop_run, mem_run, irq, video_clock_out_en}, 8'h01, "reset outputs");
        rst_n <= 1'b1;
        rchk(IDX_CLK_SRC, RST_CLK_SRC, "source reset");
        rchk(IDX_MLC_CTRL, RST_MLC, "loop control reset");
        i_pcs_host_model.write_reg(8'h50, 8'hA5);
        rchk(8'h50, 8'h00, "unmapped");
        // Hard-wired pixel settings
        wait_pix(1'b1);
        chk(pix_m, HW0_M, "hard-wired 00");
        i_pcs_host_model.set_pins(2'b01);
        for (int k = 0; k < 12 && pix_m !== HW1_M; k++) @(posedge clk_sys);
        #1;
        chk(pix_m, HW1_M, "hard-wired 01");
        chk(pix_n, HW1_N, "hard-wired 01 n");
        // VGA setup
        i_pcs_host_model.write_reg(IDX_CLK_SRC, 8'h77);
        settle();
        chk({6'h00, pix_src_synth, video_clock_out_en}, 8'h00, "external source");
        i_pcs_host_model.stop_synth(IDX_LOOP_DATA);
        i_pcs_host_model.stop_synth(IDX_PIX_DATA);
        settle();
        chk({7'h00, pix_run}, 8'h01, "run held at 0x");
        i_pcs_host_model.set_pins(2'b11);
        wait_pix(1'b0);
        chk({7'h00, loop_run}, 8'h00, "loop stopped");
        i_pcs_host_model.write_reg(IDX_MLC_CTRL, 8'h18);
        settle();
        chk({4'h0, rclk_from_pixel, loop_q}, 8'h08, "return clock");
        // Extended setup
        i_pcs_host_model.write_reg(IDX_CLK_SRC, 8'h75);
        settle();
        chk({6'h00, pix_src_synth, video_clock_out_en}, 8'h02, "synth source");
        i_pcs_host_model.write_reg(IDX_CLK_SRC, 8'h05);
        settle();
        chk({6'h00, pix_src_synth, video_clock_out_en}, 8'h03, "output enabled");
        i_pcs_host_model.load_synth(IDX_PIX_DATA, 8'hE8, 8'h1C, 8'hB0);
        i_pcs_host_model.write_reg(IDX_PTR, PTR_STAT);
        rchk(IDX_PIX_DATA, 8'h00, "not yet locked");
        i_pcs_host_model.poll_lock(IDX_PIX_DATA, ok);
        chk({7'h00, ok}, 8'h01, "pixel lock");
        chk({pix_n, pix_m, pix_p} == 24'hE81CB0 ? 8'h01 : 8'h00, 8'h01, "pixel words");
        chk({7'h00, pix_run}, 8'h01, "pixel running");
        i_pcs_host_model.write_reg(IDX_MLC_CTRL, 8'h32);
        settle();
        chk({4'h0, rclk_from_pixel, loop_q}, 8'h02, "loop divider");
        i_pcs_host_model.write_reg(IDX_PTR, PTR_N);
        rchk(IDX_PIX_DATA, 8'hE8, "read n");
        rchk(IDX_PIX_DATA, 8'h1C, "read m");
        rchk(IDX_PIX_DATA, 8'hB0, "read p");
        i_pcs_host_model.write_reg(IDX_PTR, PTR_P);
        rchk(IDX_PIX_DATA, 8'hB0, "point p");
        for (int i = 0; i < 4; i++) begin
            i_pcs_host_model.load_synth(IDX_LOOP_DATA, loop_nm[i][0], loop_nm[i][1], 8'hF1);
            i_pcs_host_model.poll_lock(IDX_LOOP_DATA, ok);
            chk({7'h00, ok}, 8'h01, "loop lock");
            i_pcs_host_model.write_reg(IDX_PTR, PTR_N);
            rchk(IDX_LOOP_DATA, loop_nm[i][0], "loop n");
            rchk(IDX_LOOP_DATA, loop_nm[i][1], "loop m");
        end
        chk({7'h00, loop_run}, 8'h01, "loop running");
        // Memory synthesizer
        i_pcs_host_model.stop_synth(IDX_MEM_DATA);
        settle();
        chk({7'h00, mem_run}, 8'h00, "memory stopped");
        i_pcs_host_model.load_synth(IDX_MEM_DATA, 8'hC0, 8'h28, 8'hB0);
        i_pcs_host_model.poll_lock(IDX_MEM_DATA, ok);
        chk({1'b0, ok, 5'h00, mem_run}, 8'h41, "memory lock");
        // Interrupts
        i_pcs_host_model.read_reg(IDX_IRQ_STAT, d);
        chk({5'h00, d[2:0]}, 8'h07, "lock events");
        chk({7'h00, irq}, 8'h00, "all masked");
        i_pcs_host_model.write_reg(IDX_IRQ_MASK, 8'h02);
        settle();
        chk({7'h00, irq}, 8'h01, "loop event unmasked");
        i_pcs_host_model.write_reg(IDX_IRQ_STAT, 8'h02);
        settle();
        chk({7'h00, irq}, 8'h00, "event cleared");
        i_pcs_host_model.read_reg(IDX_IRQ_STAT, d);
        chk({5'h00, d[2:0]}, 8'h05, "others kept");
        complete_run();
    end
endmodule
`default_nettype wire

// ===== pcs_top.sv
// Module: synthesizer programming sequencer, register file and clock routing
// Notes on behaviour
// - A cleared run enable, once effective, halts that synthesizer oscillator.
// - Pixel and loop run enables take effect only with select pins at 1x.
// - Pins 00 pick hard-wired 25.057 MHz, 01 pick 28.636 MHz pixel setting.
// - Pointer at 2C: 00 selects N, 2A selects P, 3F selects status.
// - Status bit 6 reads one once locked; host polls until set, for at most 64 reads.
// - Loop Q post-divider comes from bits 2..0 of index 39.
// - Writing 18 to index 39 routes pixel synthesizer to return clock.
// - Index 1A: 77 picks external clock zero, 75 picks pixel synthesizer.
// - Bits 6..4 of 1A at 111 disable the unused video clock output.
`timescale 1ns/10ps
`default_nettype none
module pcs_top
    import pcs_pkg::*;
#(
    parameter int LOCK_CNT = LOCK_CYCLES
) (
    input wire logic clk_sys,
    input wire logic rst_n,
    // Register port
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    // Pins
    input wire logic [1:0] hardwired_freq_select_pins,
    // Clock routing and synthesizer state
    output logic pix_run,
    output logic loop_run,
    output logic mem_run,
    output logic [7:0] pix_n,
    output logic [7:0] pix_m,
    output logic [7:0] pix_p,
    output logic [2:0] loop_q,
    output logic rclk_from_pixel,
    output logic pix_src_synth,
    output logic video_clock_out_en,
    // Interrupt
    output logic irq
);
    // ************************************
    // Pin synchroniser
    // ************************************
    logic [1:0] sel_s1;
    logic [1:0] sel_s2;
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            sel_s1 <= 2'h0;
            sel_s2 <= 2'h0;
        end else begin
            sel_s1 <= hardwired_freq_select_pins;
            sel_s2 <= sel_s1;
        end
    end
    logic prog_mode;
    assign prog_mode = sel_s2[1];

    // ************************************
    // Registers
    // ************************************
    logic [7:0] clock_source_select;
    logic [7:0] memory_loop_clock_control;
    logic [7:0] irq_mask;
    logic [7:0] irq_stat;
    pcs_word_t wsel;
    logic [7:0] word_ptr;
    // Programmed words; index 0 pixel, 1 loop, 2 memory
    logic [7:0] reg_n [3];
    logic [7:0] reg_m [3];
    logic [7:0] reg_p [3];
    logic [2:0] locked;
    logic [2:0] osc;

    logic wr_src, wr_ptr, wr_mlc, wr_msk, wr_sts;
    logic [2:0] acc_wr, acc_rd, acc;
    assign wr_src = reg_wr && reg_addr == IDX_CLK_SRC;
    assign wr_ptr = reg_wr && reg_addr == IDX_PTR;
    assign wr_mlc = reg_wr && reg_addr == IDX_MLC_CTRL;
    assign wr_msk = reg_wr && reg_addr == IDX_IRQ_MASK;
    assign wr_sts = reg_wr && reg_addr == IDX_IRQ_STAT;

    genvar gi;
    generate
        for (gi = 0; gi < 3; gi++) begin : g_acc
            logic [7:0] idx;
            assign idx = (gi == 0) ? IDX_PIX_DATA : ((gi == 1) ? IDX_LOOP_DATA : IDX_MEM_DATA);
            assign acc_wr[gi] = reg_wr && reg_addr == idx;
            assign acc_rd[gi] = reg_rd && reg_addr == idx;
            assign acc[gi] = acc_wr[gi] || acc_rd[gi];
        end
    endgenerate

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            clock_source_select <= RST_CLK_SRC;
        end else if (wr_src) begin
            clock_source_select <= reg_wdata;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            memory_loop_clock_control <= RST_MLC;
        end else if (wr_mlc) begin
            memory_loop_clock_control <= reg_wdata;
        end
    end

    // Pointer: writes set it; data accesses step N, M, P
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            wsel <= PCS_W_N;
            word_ptr <= PTR_N;
        end else if (wr_ptr) begin
            word_ptr <= reg_wdata;
            case (reg_wdata)
                PTR_N: wsel <= PCS_W_N;
                PTR_P: wsel <= PCS_W_P;
                PTR_STAT: wsel <= PCS_W_S;
                default: wsel <= PCS_W_M;
            endcase
        end else if (|acc) begin
            case (wsel)
                PCS_W_N: begin
                    wsel <= PCS_W_M;
                    word_ptr <= PTR_M;
                end
                PCS_W_M: begin
                    wsel <= PCS_W_P;
                    word_ptr <= PTR_P;
                end
                PCS_W_P: begin
                    wsel <= PCS_W_N;
                    word_ptr <= PTR_N;
                end
                default: wsel <= PCS_W_S;
            endcase
        end
    end

    generate
        for (gi = 0; gi < 3; gi++) begin : g_words
            always_ff @(posedge clk_sys or negedge rst_n) begin
                if (!rst_n) begin
                    reg_n[gi] <= RST_N;
                    reg_m[gi] <= RST_M;
                    reg_p[gi] <= (gi == 2) ? RST_P : RST_PIX_P;
                end else if (acc_wr[gi]) begin
                    case (wsel)
                        PCS_W_N: reg_n[gi] <= reg_wdata;
                        PCS_W_M: reg_m[gi] <= reg_wdata;
                        PCS_W_P: reg_p[gi] <= reg_wdata;
                        default: reg_n[gi] <= reg_n[gi];
                    endcase
                end
            end
        end
    endgenerate

    // ************************************
    // Run enables and synthesizers
    // ************************************
    // Pixel and loop hold their last effective enable while pins are 0x
    logic pix_eff, loop_eff;
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            pix_eff <= 1'b0;
            loop_eff <= 1'b0;
        end else if (prog_mode) begin
            pix_eff <= reg_p[0][P_RUN_BIT];
            loop_eff <= reg_p[1][P_RUN_BIT];
        end
    end
    logic [2:0] run_now;
    // Hard-wired pixel settings always run
    assign run_now[0] = prog_mode ? pix_eff : 1'b1;
    assign run_now[1] = loop_eff;
    assign run_now[2] = reg_p[2][P_RUN_BIT];
    // A fresh P write restarts acquisition
    logic [2:0] retune;
    assign retune = acc_wr & {3{wsel == PCS_W_P}};
    logic [1:0] sel_d;
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            sel_d <= 2'h0;
        end else begin
            sel_d <= sel_s2;
        end
    end
    logic [2:0] retune_all;
    assign retune_all = {retune[2:1], retune[0] || (sel_d != sel_s2)};

    generate
        for (gi = 0; gi < 3; gi++) begin : g_synth
            pcs_synth #(.LOCK_CNT(LOCK_CNT)) u_synth (
                .clk_sys(clk_sys),
                .rst_n(rst_n),
                .run(run_now[gi]),
                .retune(retune_all[gi]),
                .osc_on(osc[gi]),
                .locked(locked[gi])
            );
        end
    endgenerate

    // ************************************
    // Read path
    // ************************************
    function automatic logic [7:0] word_rd(input int k);
        logic [7:0] v;
        v = 8'h00;
        case (wsel)
            PCS_W_N: v = reg_n[k];
            PCS_W_M: v = reg_m[k];
            PCS_W_P: v = reg_p[k];
            default: v = {1'b0, locked[k], 6'h00};
        endcase
        return v;
    endfunction

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            reg_rdata <= 8'h00;
        end else if (reg_rd) begin
            case (reg_addr)
                IDX_CLK_SRC: reg_rdata <= clock_source_select;
                IDX_PTR: reg_rdata <= word_ptr;
                IDX_PIX_DATA: reg_rdata <= word_rd(0);
                IDX_LOOP_DATA: reg_rdata <= word_rd(1);
                IDX_MEM_DATA: reg_rdata <= word_rd(2);
                IDX_MLC_CTRL: reg_rdata <= memory_loop_clock_control;
                IDX_IRQ_STAT: reg_rdata <= irq_stat;
                IDX_IRQ_MASK: reg_rdata <= irq_mask;
                default: reg_rdata <= 8'h00;
            endcase
        end else begin
            reg_rdata <= 8'h00;
        end
    end

    // ************************************
    // Interrupts: lock gained per synthesizer
    // ************************************
    logic [2:0] locked_d;
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            locked_d <= 3'h0;
        end else begin
            locked_d <= locked;
        end
    end
    logic [2:0] lock_evt;
    assign lock_evt = locked & ~locked_d;

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            irq_stat <= 8'h00;
        end else begin
            // Set wins over a same-cycle clear
            irq_stat <= (irq_stat & ~(wr_sts ? reg_wdata : 8'h00)) | {5'h00, lock_evt};
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            irq_mask <= 8'h00;
        end else if (wr_msk) begin
            irq_mask <= reg_wdata;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            irq <= 1'b0;
        end else begin
            irq <= |(irq_stat & irq_mask);
        end
    end

    // ************************************
    // Output flops
    // ************************************
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            pix_run <= 1'b0;
            loop_run <= 1'b0;
            mem_run <= 1'b0;
            pix_n <= HW0_N;
            pix_m <= HW0_M;
            pix_p <= HW_P;
            loop_q <= 3'h0;
            rclk_from_pixel <= 1'b0;
            pix_src_synth <= 1'b0;
            video_clock_out_en <= 1'b1;
        end else begin
            pix_run <= osc[0];
            loop_run <= osc[1];
            mem_run <= osc[2];
            if (prog_mode) begin
                pix_n <= reg_n[0];
                pix_m <= reg_m[0];
                pix_p <= reg_p[0];
            end else if (sel_s2[0]) begin
                pix_n <= HW1_N;
                pix_m <= HW1_M;
                pix_p <= HW_P;
            end else begin
                pix_n <= HW0_N;
                pix_m <= HW0_M;
                pix_p <= HW_P;
            end
            loop_q <= memory_loop_clock_control[Q_MSB:0];
            rclk_from_pixel <= memory_loop_clock_control[RCLK_SEL_BIT];
            pix_src_synth <= clock_source_select[3:0] == SRC_SEL_SYNTH;
            video_clock_out_en <= clock_source_select[SRC_OFF_LSB+2:SRC_OFF_LSB] != SRC_OFF_ALL;
        end
    end

    // ************************************
    // Assertions
    // ************************************
    property p_stop_halts;
        @(posedge clk_sys) disable iff (!rst_n)
        (prog_mode && !reg_p[1][P_RUN_BIT]) |-> ##3 !loop_run;
    endproperty
    a_stop_halts: assert property (p_stop_halts) else $error("loop not halted");
    property p_pins_gate;
        @(posedge clk_sys) disable iff (!rst_n)
        !prog_mode |=> $stable(loop_eff);
    endproperty
    a_pins_gate: assert property (p_pins_gate) else $error("enable changed with pins at 0x");
    property p_hw1;
        @(posedge clk_sys) disable iff (!rst_n)
        (sel_s2 == 2'b01) |=> (pix_m == HW1_M);
    endproperty
    a_hw1: assert property (p_hw1) else $error("wrong hard-wired setting");
    property p_ptr_stat;
        @(posedge clk_sys) disable iff (!rst_n)
        (wr_ptr && reg_wdata == PTR_STAT) |=> wsel == PCS_W_S;
    endproperty
    a_ptr_stat: assert property (p_ptr_stat) else $error("pointer not at status");
    property p_lock_read;
        @(posedge clk_sys) disable iff (!rst_n)
        (acc_rd[0] && wsel == PCS_W_S) |=> reg_rdata[STAT_LOCK_BIT] == $past(locked[0]);
    endproperty
    a_lock_read: assert property (p_lock_read) else $error("lock bit wrong");
    property p_q;
        @(posedge clk_sys) disable iff (!rst_n)
        wr_mlc |=> ##1 loop_q == $past(reg_wdata[2:0], 2);
    endproperty
    a_q: assert property (p_q) else $error("Q not taken");
    property p_rclk;
        @(posedge clk_sys) disable iff (!rst_n)
        (wr_mlc && reg_wdata == RST_MLC) |=> ##1 rclk_from_pixel;
    endproperty
    a_rclk: assert property (p_rclk) else $error("return clock not routed");
    property p_video_clock_out;
        @(posedge clk_sys) disable iff (!rst_n)
        (wr_src && reg_wdata[6:4] == SRC_OFF_ALL) |=> ##1 !video_clock_out_en;
    endproperty
    a_video_clock_out: assert property (p_video_clock_out) else $error("video clock not disabled");
    property p_step;
        @(posedge clk_sys) disable iff (!rst_n)
        (acc_wr[1] && !wr_ptr && wsel == PCS_W_N) |=> wsel == PCS_W_M;
    endproperty
    a_step: assert property (p_step) else $error("pointer did not advance");
    c_lock: cover property (@(posedge clk_sys) disable iff (!rst_n) lock_evt[0]);
    c_irq: cover property (@(posedge clk_sys) disable iff (!rst_n) irq);
    c_stop: cover property (@(posedge clk_sys) disable iff (!rst_n) $fell(loop_run));
endmodule
`default_nettype wire
